// File: fspc_ctrl.v
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "fspc_regs.vh"
// Flash self-programming sequencer with AXI4-Lite registers
module fspc_ctrl #(
   // Divides every microsecond part; above one only to shorten simulation
   parameter [31:0] P_TIME_DIV = 32'h00000001,
   // Microsecond parts turned into cycles
   parameter [31:0] P_INIT_CYC = `FSPC_US_INIT * `FSPC_CLK_MHZ / P_TIME_DIV,
   parameter [31:0] P_ERASE_CYC = `FSPC_US_ERASE * `FSPC_CLK_MHZ / P_TIME_DIV,
   parameter [31:0] P_WRITE_CYC = `FSPC_US_WRITE * `FSPC_CLK_MHZ / P_TIME_DIV,
   parameter [31:0] P_WORD_CYC = `FSPC_US_WORD * `FSPC_CLK_MHZ / P_TIME_DIV,
   parameter [31:0] P_VERIFY_CYC = `FSPC_US_VERIFY * `FSPC_CLK_MHZ / P_TIME_DIV,
   parameter [31:0] P_BLANK_CYC = `FSPC_US_BLANK * `FSPC_CLK_MHZ / P_TIME_DIV,
   parameter [31:0] P_GI03_CYC = `FSPC_US_GI03 * `FSPC_CLK_MHZ / P_TIME_DIV,
   parameter [31:0] P_GI04_CYC = `FSPC_US_GI04 * `FSPC_CLK_MHZ / P_TIME_DIV,
   parameter [31:0] P_GI05_CYC = `FSPC_US_GI05 * `FSPC_CLK_MHZ / P_TIME_DIV,
   parameter [31:0] P_SETINFO_CYC = `FSPC_US_SETINFO * `FSPC_CLK_MHZ / P_TIME_DIV,
   parameter [31:0] P_MODECHK_CYC = `FSPC_US_MODECHK * `FSPC_CLK_MHZ / P_TIME_DIV,
   parameter [31:0] P_EEPWR_CYC = `FSPC_US_EEPWR * `FSPC_CLK_MHZ / P_TIME_DIV,
   parameter [31:0] P_EEWORD_CYC = `FSPC_US_EEWORD * `FSPC_CLK_MHZ / P_TIME_DIV,
   parameter [31:0] P_RESTART_CYC = `FSPC_US_RESTART * `FSPC_CLK_MHZ / P_TIME_DIV
) (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // AXI4-Lite write address and data
   input wire [7:0] awaddr,
   input wire awvalid,
   output wire awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output wire wready,
   // AXI4-Lite write response
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   // AXI4-Lite read
   input wire [7:0] araddr,
   input wire arvalid,
   output wire arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   // Interrupt request flags, four bytes of flag registers
   input wire [31:0] irq_request_flags,
   // Pins and CPU state
   input wire flash_mode_pin,
   input wire cpu_on_subsys_clk,
   input wire stop_mode_req,
   // Oscillator and mode outputs
   output reg hs_osc_run,
   output reg self_prog_active,
   output reg self_prog_busy
);
   // One-hot sequencer states
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_START = 4'h2;
   localparam [3:0] ST_RUN = 4'h4;
   localparam [3:0] ST_END = 4'h8;

   // Bus-side holding registers
   reg aw_full_reg; // Write address taken
   reg w_full_reg; // Write data taken
   reg [7:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;

   // Software-visible state and the oscillator settling counter
   reg hs_osc_stop_bit; // Oscillator stop request
   reg hs_osc_stable_bit; // Oscillator settled
   reg [3:0] settle_reg; // Settling counter
   reg cpu_clock_source_bit; // CPU clock source select
   reg [31:0] irq_mask_flags; // Four mask bytes, 1 = masked
   reg done_reg; // Sticky completion flag
   reg err_reg; // Sticky refused-command flag

   // Sequencer state
   reg [3:0] state_reg;
   reg [3:0] func_reg; // Function running
   reg ack_en_reg; // Interrupts may suspend it
   reg susp_reg; // Operation suspended, waits for re-entry
   reg [3:0] susp_func_reg;
   reg [31:0] susp_left_reg; // Cycles left at suspension
   reg after_cold_start_reg; // Previous start found osc stopped
   reg osc_was_stopped_reg; // Oscillator state at start entry

   // Timer hookup
   reg tmr_load;
   reg [31:0] tmr_val;
   wire tmr_expire;
   wire [31:0] tmr_left;
   wire tmr_abort;

   // Command decode
   wire wr_fire;
   wire cmd_wr;
   wire [3:0] cmd_func;
   wire [7:0] cmd_words;
   wire irq_pending;
   wire wr_hit;
   wire rd_hit;
   reg [31:0] base_cyc;
   reg cmd_ack;

   // Write channels accept independently; response after both
   assign awready = !aw_full_reg;
   assign wready = !w_full_reg;
   assign arready = !rvalid;
   assign wr_fire = aw_full_reg && w_full_reg && !bvalid;
   assign wr_hit = (aw_addr_reg == `FSPC_ADDR_CMD) || (aw_addr_reg == `FSPC_ADDR_STATUS) ||
                   (aw_addr_reg == `FSPC_ADDR_OSC) || (aw_addr_reg == `FSPC_ADDR_MCLK) ||
                   (aw_addr_reg == `FSPC_ADDR_MASK) || (aw_addr_reg == `FSPC_ADDR_IRQ);
   assign rd_hit = (araddr == `FSPC_ADDR_CMD) || (araddr == `FSPC_ADDR_STATUS) ||
                   (araddr == `FSPC_ADDR_OSC) || (araddr == `FSPC_ADDR_MCLK) ||
                   (araddr == `FSPC_ADDR_MASK) || (araddr == `FSPC_ADDR_IRQ);
   // Command needs the low byte lane for the function code
   assign cmd_wr = wr_fire && (aw_addr_reg == `FSPC_ADDR_CMD) && w_strb_reg[0];
   assign cmd_func = w_data_reg[3:0];
   assign cmd_words = w_data_reg[15:8];

   // Masked requests do not count, even with interrupts disabled
   assign irq_pending = |(irq_request_flags & ~irq_mask_flags);
   // Suspension empties the timer; the count is saved instead
   assign tmr_abort = (state_reg == ST_RUN) && ack_en_reg && irq_pending;

   // Address and data capture
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else begin
         if (awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= {awaddr[7:2], 2'b00};
         end else if (wr_fire) begin
            aw_full_reg <= 1'b0;
         end
         if (wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
         end else if (wr_fire) begin
            w_full_reg <= 1'b0;
         end
      end
   end

   // Write response, unmapped addresses answer with an error
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp <= `FSPC_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp <= wr_hit ? `FSPC_RESP_OKAY : `FSPC_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Register writes other than the command
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hs_osc_stop_bit <= 1'b0;
         cpu_clock_source_bit <= 1'b0;
         irq_mask_flags <= `FSPC_MASK_RST;
      end else if (wr_fire) begin
         if (aw_addr_reg == `FSPC_ADDR_OSC && w_strb_reg[0]) begin
            hs_osc_stop_bit <= w_data_reg[`FSPC_OSC_STOP_BIT];
         end
         if (aw_addr_reg == `FSPC_ADDR_MCLK && w_strb_reg[0]) begin
            cpu_clock_source_bit <= w_data_reg[`FSPC_CPU_SRC_BIT];
         end
         if (aw_addr_reg == `FSPC_ADDR_MASK) begin
            if (w_strb_reg[0]) irq_mask_flags[7:0] <= w_data_reg[7:0];
            if (w_strb_reg[1]) irq_mask_flags[15:8] <= w_data_reg[15:8];
            if (w_strb_reg[2]) irq_mask_flags[23:16] <= w_data_reg[23:16];
            if (w_strb_reg[3]) irq_mask_flags[31:24] <= w_data_reg[31:24];
         end
      end
   end

   // Read data, registered; reserved bits read zero
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rresp <= `FSPC_RESP_OKAY;
         rdata <= 32'h00000000;
      end else if (arvalid && !rvalid) begin
         rvalid <= 1'b1;
         rresp <= rd_hit ? `FSPC_RESP_OKAY : `FSPC_RESP_SLVERR;
         rdata <= 32'h00000000;
         case (araddr & 8'hFC)
            `FSPC_ADDR_CMD: rdata <= {28'h0000000, func_reg};
            `FSPC_ADDR_STATUS: rdata <= {27'h0000000, err_reg, done_reg, susp_reg,
                                        self_prog_active, self_prog_busy};
            `FSPC_ADDR_OSC: rdata <= {24'h000000, hs_osc_stable_bit, 6'h00, hs_osc_stop_bit};
            `FSPC_ADDR_MCLK: rdata <= {30'h00000000, cpu_clock_source_bit, 1'b0};
            `FSPC_ADDR_MASK: rdata <= irq_mask_flags;
            `FSPC_ADDR_IRQ: rdata <= irq_request_flags;
            default: rdata <= 32'h00000000;
         endcase
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // Oscillator control; the stop bit and stop mode lose to programming
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hs_osc_run <= 1'b1;
         hs_osc_stable_bit <= 1'b0;
         settle_reg <= 4'h0;
      end else begin
         hs_osc_run <= self_prog_active || (!hs_osc_stop_bit && !stop_mode_req);
         // Stable only after the oscillator has run a settling time
         if (!hs_osc_run) begin
            settle_reg <= 4'h0;
            hs_osc_stable_bit <= 1'b0;
         end else if (settle_reg != `FSPC_OSC_SETTLE) begin
            settle_reg <= settle_reg + 4'h1;
         end else begin
            hs_osc_stable_bit <= 1'b1;
         end
      end
   end

   // Duration of a function with its fixed and time parts
   always @* begin
      base_cyc = 32'h00000000;
      cmd_ack = 1'b0;
      case (cmd_func)
         `FSPC_F_INIT: base_cyc = `FSPC_CYC_INIT + P_INIT_CYC;
         `FSPC_F_ERASE: begin
            base_cyc = `FSPC_CYC_BLOCK + P_ERASE_CYC;
            cmd_ack = 1'b1;
         end
         `FSPC_F_WRITE: begin
            // Word count is in four-byte units
            base_cyc = `FSPC_CYC_WRITE + P_WRITE_CYC + cmd_words * P_WORD_CYC;
            cmd_ack = 1'b1;
         end
         `FSPC_F_VERIFY: begin
            base_cyc = `FSPC_CYC_BLOCK + P_VERIFY_CYC;
            cmd_ack = 1'b1;
         end
         `FSPC_F_BLANK: begin
            base_cyc = `FSPC_CYC_BLOCK + P_BLANK_CYC;
            cmd_ack = 1'b1;
         end
         `FSPC_F_GI03: base_cyc = `FSPC_CYC_GI03 + P_GI03_CYC;
         `FSPC_F_GI04: base_cyc = `FSPC_CYC_GI04 + P_GI04_CYC;
         `FSPC_F_GI05: base_cyc = `FSPC_CYC_GI05 + P_GI05_CYC;
         `FSPC_F_SETINFO: begin
            base_cyc = `FSPC_CYC_SETINFO + P_SETINFO_CYC;
            cmd_ack = 1'b1;
         end
         `FSPC_F_MODECHK: base_cyc = `FSPC_CYC_MODECHK + P_MODECHK_CYC;
         `FSPC_F_EEPWR: begin
            base_cyc = `FSPC_CYC_WRITE + P_EEPWR_CYC + cmd_words * P_EEWORD_CYC;
            cmd_ack = 1'b1;
         end
         default: base_cyc = 32'h00000000;
      endcase
   end

   // Timer load requests from the sequencer
   always @* begin
      tmr_load = 1'b0;
      tmr_val = 32'h00000000;
      if (state_reg == ST_IDLE && cmd_wr) begin
         if (cmd_func == `FSPC_F_START) begin
            tmr_load = 1'b1;
            tmr_val = `FSPC_CYC_START;
         end else if (cmd_func == `FSPC_F_END) begin
            tmr_load = 1'b1;
            tmr_val = `FSPC_CYC_END;
         end else begin
            tmr_load = 1'b1;
            // Restart penalty only right after a cold start
            tmr_val = after_cold_start_reg ? base_cyc + P_RESTART_CYC : base_cyc;
         end
      end else if (state_reg == ST_START && tmr_expire && susp_reg) begin
         tmr_load = 1'b1;
         tmr_val = susp_left_reg;
      end
   end

   // Sequencer; a refused command raises the error flag and still loads func_reg
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         func_reg <= `FSPC_F_START;
         ack_en_reg <= 1'b0;
         susp_reg <= 1'b0;
         susp_func_reg <= `FSPC_F_START;
         susp_left_reg <= 32'h00000000;
         after_cold_start_reg <= 1'b0;
         osc_was_stopped_reg <= 1'b0;
         self_prog_active <= 1'b0;
         self_prog_busy <= 1'b0;
         done_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         // Software clears flags by writing ones; a set in the same cycle wins
         if (wr_fire && aw_addr_reg == `FSPC_ADDR_STATUS && w_strb_reg[0]) begin
            if (w_data_reg[`FSPC_ST_DONE]) done_reg <= 1'b0;
            if (w_data_reg[`FSPC_ST_ERR]) err_reg <= 1'b0;
         end
         case (state_reg)
            ST_IDLE: begin
               if (cmd_wr) begin
                  func_reg <= cmd_func;
                  if (cmd_func == `FSPC_F_START) begin
                     // Refused on subsystem clock or without the mode pin
                     if (cpu_on_subsys_clk || !flash_mode_pin) begin
                        err_reg <= 1'b1;
                     end else begin
                        state_reg <= ST_START;
                        self_prog_active <= 1'b1;
                        self_prog_busy <= 1'b1;
                        osc_was_stopped_reg <= !hs_osc_stable_bit;
                     end
                  end else if (!self_prog_active) begin
                     err_reg <= 1'b1;
                  end else if (cmd_func == `FSPC_F_END) begin
                     state_reg <= ST_END;
                     self_prog_busy <= 1'b1;
                     ack_en_reg <= 1'b0;
                  end else if (cmd_func > `FSPC_F_EEPWR) begin
                     err_reg <= 1'b1;
                  end else begin
                     state_reg <= ST_RUN;
                     self_prog_busy <= 1'b1;
                     ack_en_reg <= cmd_ack;
                     after_cold_start_reg <= 1'b0;
                  end
               end
            end
            ST_START: begin
               // Start is short and never suspended
               if (tmr_expire) begin
                  if (susp_reg) begin
                     state_reg <= ST_RUN;
                     func_reg <= susp_func_reg;
                     ack_en_reg <= 1'b1;
                     susp_reg <= 1'b0;
                     after_cold_start_reg <= 1'b0;
                  end else begin
                     state_reg <= ST_IDLE;
                     self_prog_busy <= 1'b0;
                     done_reg <= 1'b1;
                     after_cold_start_reg <= osc_was_stopped_reg;
                  end
               end
            end
            ST_RUN: begin
               if (tmr_abort) begin
                  // Leave the mode and keep the rest for re-entry
                  state_reg <= ST_IDLE;
                  self_prog_active <= 1'b0;
                  self_prog_busy <= 1'b0;
                  susp_reg <= 1'b1;
                  susp_func_reg <= func_reg;
                  susp_left_reg <= tmr_left;
               end else if (tmr_expire) begin
                  state_reg <= ST_IDLE;
                  self_prog_busy <= 1'b0;
                  done_reg <= 1'b1;
               end
            end
            ST_END: begin
               // Fixed length, interrupts never looked at
               if (tmr_expire) begin
                  state_reg <= ST_IDLE;
                  self_prog_active <= 1'b0;
                  self_prog_busy <= 1'b0;
                  done_reg <= 1'b1;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               self_prog_busy <= 1'b0;
            end
         endcase
      end
   end

   // Function pacing counter
   fspc_timer u_timer (
      .mclk(mclk),
      .rst_n(rst_n),
      .load(tmr_load),
      .load_val(tmr_val),
      .abort(tmr_abort),
      .expire(tmr_expire),
      .remaining(tmr_left)
   );
endmodule
`default_nettype wire

// File: fspc_regs.vh
// What this block does
// - CPU firmware rewrites flash via self-programming.
// - No self-programming while CPU runs on subsystem clock.
// - Self-programming forces internal high-speed oscillator on.
// - Stop instruction cannot halt oscillator while programming.
// - Pending interrupt request suspends erase, write, verify, blank, setinfo and eepwr.
// - Unmasked requests suspend even when interrupts disabled.
// - Re-entering mode resumes the suspended operation.
// - Writes count four-byte words; time linear in words.
// - Restart penalty only for function right after a start that found the oscillator stopped.
// - Stable bit 7 oscillator reg; source bit 1.
// - End function takes 34 CPU cycles, no interrupts.
`ifndef FSPC_REGS_VH
`define FSPC_REGS_VH

// Register byte addresses
`define FSPC_ADDR_CMD 8'h00
`define FSPC_ADDR_STATUS 8'h04
`define FSPC_ADDR_OSC 8'h08
`define FSPC_ADDR_MCLK 8'h0C
`define FSPC_ADDR_MASK 8'h10
`define FSPC_ADDR_IRQ 8'h14

// Field positions
`define FSPC_OSC_STOP_BIT 0
`define FSPC_OSC_STABLE_BIT 7
`define FSPC_CPU_SRC_BIT 1
`define FSPC_ST_BUSY 0
`define FSPC_ST_ACTIVE 1
`define FSPC_ST_SUSP 2
`define FSPC_ST_DONE 3
`define FSPC_ST_ERR 4

// Reset values and oscillator settling count
`define FSPC_MASK_RST 32'hFFFFFFFF
`define FSPC_OSC_SETTLE 4'hF

// Bus responses
`define FSPC_RESP_OKAY 2'h0
`define FSPC_RESP_SLVERR 2'h2

// Function codes in the command register
`define FSPC_F_START 4'h0
`define FSPC_F_END 4'h1
`define FSPC_F_INIT 4'h2
`define FSPC_F_ERASE 4'h3
`define FSPC_F_WRITE 4'h4
`define FSPC_F_VERIFY 4'h5
`define FSPC_F_BLANK 4'h6
`define FSPC_F_GI03 4'h7
`define FSPC_F_GI04 4'h8
`define FSPC_F_GI05 4'h9
`define FSPC_F_SETINFO 4'hA
`define FSPC_F_MODECHK 4'hB
`define FSPC_F_EEPWR 4'hC

// CPU clock rate in MHz (cycles per microsecond)
`define FSPC_CLK_MHZ 10
// Fixed CPU-cycle parts of each function
`define FSPC_CYC_START 34
`define FSPC_CYC_END 34
`define FSPC_CYC_INIT 55
`define FSPC_CYC_BLOCK 179
`define FSPC_CYC_WRITE 333
`define FSPC_CYC_GI03 180
`define FSPC_CYC_GI04 190
`define FSPC_CYC_GI05 350
`define FSPC_CYC_SETINFO 80
`define FSPC_CYC_MODECHK 36
// Time parts of each function in microseconds
`define FSPC_US_INIT 1140
`define FSPC_US_ERASE 353193
`define FSPC_US_WRITE 1154
`define FSPC_US_WORD 2142
`define FSPC_US_VERIFY 25596
`define FSPC_US_BLANK 12805
`define FSPC_US_GI03 1065
`define FSPC_US_GI04 1056
`define FSPC_US_GI05 1041
`define FSPC_US_SETINFO 753218
`define FSPC_US_MODECHK 952
`define FSPC_US_EEPWR 1297
`define FSPC_US_EEWORD 2286
`define FSPC_US_RESTART 772

`endif

// File: fspc_timer.v
`timescale 1ns/100ps
`default_nettype none
// Down counter pacing one library function
module fspc_timer (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Control
   input wire load,
   input wire [31:0] load_val,
   input wire abort,
   // Status
   output wire expire,
   output wire [31:0] remaining
);
   reg [31:0] cnt_reg; // Cycles left, zero when idle

   // Expire on the last counted cycle, even when a resume reloads on it
   assign expire = (cnt_reg == 32'h00000001) && !abort;
   assign remaining = cnt_reg;

   // Load wins over counting; abort freezes nothing, it empties
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 32'h00000000;
      end else if (load) begin
         cnt_reg <= load_val;
      end else if (abort) begin
         cnt_reg <= 32'h00000000;
      end else if (cnt_reg != 32'h00000000) begin
         cnt_reg <= cnt_reg - 32'h00000001;
      end
   end
endmodule
`default_nettype wire

// File: fspc_ctrl_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level watch on the sequencer
module fspc_ctrl_monitor (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register bus
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   // Pins and state
   input wire logic flash_mode_pin,
   input wire logic cpu_on_subsys_clk,
   input wire logic stop_mode_req,
   input wire logic hs_osc_run,
   input wire logic self_prog_active,
   input wire logic self_prog_busy
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Address and data taken on one edge
   wire wr_both = awvalid && awready && wvalid && wready;
   a_osc_forced_on: assert property (self_prog_active |=> hs_osc_run)
      else $error("oscillator off during programming");
   a_stop_ignored: assert property (self_prog_active && stop_mode_req |=> hs_osc_run)
      else $error("stop halted the oscillator");
   a_start_refused: assert property ((cpu_on_subsys_clk || !flash_mode_pin) && !self_prog_active |=> !self_prog_active)
      else $error("mode entered with bad clock or pin");
   // End call: busy for exactly 34 cycles, effect one edge after the take
   a_end_cycles: assert property (wr_both && awaddr[7:2] == 6'h0 && wstrb[0] && wdata[3:0] == 4'h1
      && self_prog_active && !self_prog_busy |-> ##2 self_prog_busy ##33 self_prog_busy ##1 !self_prog_busy)
      else $error("end call length wrong");
   a_write_answer: assert property (wr_both |-> ##2 bvalid)
      else $error("write response late");
   a_unmapped_write: assert property (wr_both && awaddr[7:2] > 6'h5 |-> ##2 bresp == 2'h2)
      else $error("unmapped write not refused");
   a_read_answer: assert property (arvalid && arready |-> ##[1:2] rvalid)
      else $error("read data late");
   a_unmapped_read: assert property (arvalid && arready && araddr[7:2] > 6'h5 |-> ##[1:2] rvalid && rresp == 2'h2)
      else $error("unmapped read not refused");
endmodule
bind fspc_ctrl fspc_ctrl_monitor mon (.*);
`default_nettype wire

// File: fspc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// Firmware side: library calls as register accesses, plus pin levels
module fspc_cpu_model (
   // Clock
   input wire logic mclk,
   // Register bus master
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready,
   // Pins and pending requests
   output logic [31:0] irq_request_flags,
   output logic flash_mode_pin,
   output logic cpu_on_subsys_clk,
   output logic stop_mode_req
);
   bit ta;
   bit tw;
   // Library calls come from an entry routine kept in the low 32 KB
   localparam logic [15:0] ENTRY_ADDR = 16'h0100;
   // Idle bus, main clock, mode pin high
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
      {irq_request_flags, cpu_on_subsys_clk, stop_mode_req} = '0;
      flash_mode_pin = 1'b1;
   end
   // Pin levels just after an edge; flags are pending requests with interrupts disabled
   task pins(input logic [31:0] irq, input logic pin, input logic sub, input logic stp);
      @(posedge mclk);
      irq_request_flags <= irq;
      flash_mode_pin <= pin;
      cpu_on_subsys_clk <= sub;
      stop_mode_req <= stp;
   endtask
   // One write; each channel released at its own handshake
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      {awaddr, wdata, wstrb} <= {a, d, 4'hF};
      {awvalid, wvalid, bready} <= 3'h7;
      ta = 0;
      tw = 0;
      while (!(ta && tw)) begin
         @(posedge mclk);
         ta = ta | awready;
         tw = tw | wready;
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      do @(posedge mclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   // One read
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do @(posedge mclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge mclk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: tb_flash_self_program_control.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s: expected %0h seen %0h", n, e, g); end end
// Self-checking bench for the self-programming sequencer
module tb_flash_self_program_control;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   wire [7:0] awaddr, araddr;
   wire [31:0] wdata, rdata, irq_request_flags;
   wire [3:0] wstrb;
   wire [1:0] bresp, rresp;
   wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   wire flash_mode_pin, cpu_on_subsys_clk, stop_mode_req, hs_osc_run, self_prog_active, self_prog_busy;
   int fail_count = 0;
   int comparisons = 0;
   int n;
   logic [31:0] d;
   logic [1:0] r;
   // Function code beside expected status: suspended for interruptible ones, else active and done
   logic [11:0] rows [11] = '{12'h20A, 12'h304, 12'h404, 12'h504, 12'h604, 12'h70A, 12'h80A, 12'h90A, 12'hA04,
      12'hB0A, 12'hC04};
   // Microsecond parts divided by 1000 so the run stays brief
   fspc_ctrl #(.P_TIME_DIV(1000)) uut (.*);
   fspc_cpu_model cpu (.*);
   always #50 mclk = ~mclk;
   // One call; n counts the cycles busy is seen high
   task run(input logic [3:0] f, input logic [7:0] w);
      cpu.wr(8'h00, {16'h0, w, 4'h0, f}, r);
      n = 0;
      while (self_prog_busy === 1'b1 && n < 9000) begin
         @(posedge mclk);
         n++;
      end
      // A call that never ends is a mismatch
      if (n == 9000) fail_count++;
   endtask
   // Read a register and compare
   task rchk(input logic [7:0] a, input logic [31:0] e);
      cpu.rd(a, d, r);
      `CHK($sformatf("reg %0h", a), e, d)
   endtask
   // Verdict, reached from the sequence end or the watchdog
   task report_and_stop;
      $display("mismatches %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Hang guard, well beyond the expected run
   initial begin
      #3000000;
      fail_count++;
      report_and_stop;
   end
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      cpu.wr(8'h10, 32'h0, r);
      run(4'h0, 8'h0);
      `CHK("active", 1'b1, self_prog_active)
      `CHK("entry", 1'b1, cpu.ENTRY_ADDR <= 16'h7FFF)
      // Each function with an unmasked request pending
      foreach (rows[i]) begin
         cpu.wr(8'h04, 32'h18, r);
         cpu.pins(32'h0100_0000, 1'b1, 1'b0, 1'b0);
         run(rows[i][11:8], 8'h1);
         rchk(8'h04, {24'h0, rows[i][7:0]});
         cpu.pins(32'h0, 1'b1, 1'b0, 1'b0);
         if (rows[i][2]) begin
            run(4'h0, 8'h0);
            rchk(8'h04, 32'h0A);
         end
      end
      run(4'h1, 8'h0);
      `CHK("end cycles", 34, n)
      // Stop bit halts the oscillator outside programming
      cpu.wr(8'h08, 32'h1, r);
      repeat (4) @(posedge mclk);
      `CHK("osc", 1'b0, hs_osc_run)
      rchk(8'h08, 32'h01);
      cpu.wr(8'h04, 32'h18, r);
      cpu.pins(32'h0, 1'b1, 1'b1, 1'b0);
      run(4'h0, 8'h0);
      rchk(8'h04, 32'h10);
      cpu.wr(8'h04, 32'h18, r);
      cpu.pins(32'h0, 1'b0, 1'b0, 1'b0);
      run(4'h0, 8'h0);
      rchk(8'h04, 32'h10);
      // Start with stop requested: oscillator forced, penalty only on the next call
      cpu.pins(32'h0, 1'b1, 1'b0, 1'b1);
      run(4'h0, 8'h0);
      `CHK("osc", 1'b1, hs_osc_run)
      run(4'h2, 8'h0);
      `CHK("init cycles", 73, n)
      run(4'h2, 8'h0);
      `CHK("init cycles", 66, n)
      run(4'h4, 8'h3);
      `CHK("write cycles", 407, n)
      // Masked request leaves erase running
      cpu.wr(8'h10, 32'h0100_0000, r);
      cpu.pins(32'h0100_0000, 1'b1, 1'b0, 1'b0);
      rchk(8'h14, 32'h0100_0000);
      run(4'h3, 8'h0);
      `CHK("erase cycles", 3710, n)
      cpu.wr(8'h18, 32'h0, r);
      `CHK("bresp", 2'h2, r)
      cpu.rd(8'h1C, d, r);
      `CHK("rresp", 2'h2, r)
      // Reset in mid-erase
      cpu.wr(8'h00, 32'h3, r);
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      `CHK("osc", 1'b1, hs_osc_run)
      `CHK("busy", 1'b0, self_prog_busy)
      rst_n <= 1'b1;
      rchk(8'h10, 32'hFFFFFFFF);
      rchk(8'h04, 32'h0);
      report_and_stop;
   end
endmodule
`default_nettype wire
